// ### inc/pds_pkg.sv
// package for the pin default and reset state block
// assumes a single 200 MHz clock domain and an AHB-Lite register bus
package pds_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] PDS_CTRL_OFS = 8'h00;
    localparam logic [7:0] PDS_SEL0_OFS = 8'h04;
    localparam logic [7:0] PDS_SEL1_OFS = 8'h08;
    localparam logic [7:0] PDS_STAT_OFS = 8'h0c;
    localparam logic [7:0] PDS_DRV_OFS = 8'h10;
    localparam logic [7:0] PDS_IN_OFS = 8'h14;
    // ==========================================================
    // control fields
    localparam int PDS_CTRL_DONE = 0;
    localparam int PDS_CTRL_PRESENT = 1;
    localparam int PDS_CTRL_WAKE_EN = 2;
    localparam int PDS_CTRL_SUSP_PD = 3;
    localparam int PDS_CTRL_CONFIGURED = 4;
    localparam int PDS_CTRL_SUSPEND = 5;
    localparam int PDS_UP_W = 10;
    localparam int PDS_LO_W = 8;
    localparam int PDS_UP_PD_BIT = 7;
    localparam logic [31:0] PDS_CTRL_RST = 32'h0000_0000;
    localparam int PDS_SEL_PINS = 5;
    // ==========================================================
    // lower port default roles: bit positions and pad masks
    localparam int PDS_LO_TXD = 0;
    localparam int PDS_LO_RXD = 1;
    localparam int PDS_LO_RTS = 2;
    localparam int PDS_LO_CTS = 3;
    localparam int PDS_LO_DTR = 4;
    localparam int PDS_LO_DSR = 5;
    localparam int PDS_LO_DCD = 6;
    localparam int PDS_LO_RI = 7;
    localparam logic [7:0] PDS_LO_OE_MASK = 8'h15;
    localparam logic [7:0] PDS_LO_IN_MASK = 8'hea;
    // ==========================================================
    // upper port functions, two bits per pin across sel0/sel1
    localparam logic [1:0] PDS_FN_PULLUP = 2'h0;
    localparam logic [1:0] PDS_FN_DRIVE0 = 2'h1;
    localparam logic [1:0] PDS_FN_DRIVE1 = 2'h2;
    localparam logic [1:0] PDS_FN_POWER_ENABLE_N = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // pad control for a group of pins
    typedef struct packed {
        logic [PDS_UP_W-1:0] out;
        logic [PDS_UP_W-1:0] oe;
        logic [PDS_UP_W-1:0] pu;
        logic [PDS_UP_W-1:0] pd;
    } pds_pad_t;
endpackage : pds_pkg

// ### rtl/pds_pins.sv
// pin default and reset state logic with an AHB-Lite register slave
// assumes hresetn is the device reset and all pins are sampled on hclk
// Functional notes
// - memory select pin floats while reset is active
// - memory clock floats in reset, driven by the device afterwards
// - memory data pin stays undriven throughout reset
// - lower bits 1, 3, 5, 6, 7 are receive, cts, dsr, dcd, ring inputs
// - with wake enabled, ring indicator low while suspended requests host resume
// - upper pins take stored function; without memory float with pull-up
// - without memory upper pin 7 floats with pull-down
// - input pins are weakly pulled up toward supply
// - optional weak pull-down on inputs while suspended
// - power enable low once configured, high during suspend
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pds_pins
    import pds_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mem_cs_in,
    input wire logic mem_clk_in,
    input wire logic mem_data_in,
    output logic cfg_mem_select_o,
    output logic cfg_mem_select_oe,
    output logic cfg_mem_clock_o,
    output logic cfg_mem_clock_oe,
    output logic cfg_mem_data_o,
    output logic cfg_mem_data_oe,
    output logic cfg_mem_data_i,
    input wire logic uart_txd,
    input wire logic uart_rts_n,
    input wire logic uart_dtr_n,
    output logic uart_rxd,
    output logic uart_cts_n,
    output logic uart_dsr_n,
    output logic uart_dcd_n,
    output logic ring_indicator_n,
    input wire logic [PDS_LO_W-1:0] lower_port_in,
    output logic [PDS_LO_W-1:0] lower_port_out,
    output logic [PDS_LO_W-1:0] lower_port_oe,
    output logic [PDS_LO_W-1:0] lower_port_pu,
    output logic [PDS_LO_W-1:0] lower_port_pd,
    input wire logic [PDS_UP_W-1:0] upper_port_in,
    output pds_pad_t upper_pad,
    output logic power_enable_n,
    output logic resume_req
);
    // ==========================================================
    // bus slave
    logic [31:0] ctrl_q;
    logic [31:0] sel0_q;
    logic [31:0] sel1_q;
    logic wr_q;
    logic [7:0] wa_q;
    logic acc;
    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign hreadyout = 1'b1; // zero wait state
    assign hresp = 1'b0;
    // write address latched in the address phase
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc && hwrite;
            wa_q <= haddr;
        end
    // control and select registers
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            ctrl_q <= PDS_CTRL_RST;
            sel0_q <= 32'h0000_0000;
            sel1_q <= 32'h0000_0000;
        end
        else if (wr_q)
        begin
            if (wa_q == PDS_CTRL_OFS)
                ctrl_q <= hwdata;
            if (wa_q == PDS_SEL0_OFS)
                sel0_q <= hwdata;
            if (wa_q == PDS_SEL1_OFS)
                sel1_q <= hwdata;
        end
    logic done;
    logic present;
    logic suspend;
    assign done = ctrl_q[PDS_CTRL_DONE];
    assign present = ctrl_q[PDS_CTRL_PRESENT];
    assign suspend = ctrl_q[PDS_CTRL_SUSPEND];
    // ==========================================================
    // memory pins: float during reset, the async reset clears enables
    logic mem_oe_q;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            mem_oe_q <= 1'b0;
        else
            mem_oe_q <= 1'b1;
    assign cfg_mem_select_o = mem_cs_in;
    assign cfg_mem_select_oe = mem_oe_q && hresetn;
    assign cfg_mem_clock_o = mem_clk_in;
    assign cfg_mem_clock_oe = mem_oe_q && hresetn;
    assign cfg_mem_data_o = mem_data_in;
    // data pin direction is owned by the read engine only after reset
    assign cfg_mem_data_oe = mem_oe_q && hresetn && ctrl_q[PDS_CTRL_PRESENT] && !done;
    assign cfg_mem_data_i = 1'b0; // reserved: the reader samples the data pad on its own side
    // ==========================================================
    // lower port default roles
    logic pd_on;
    // pull-down only while suspended, so pins outside suspend keep their pull-ups
    assign pd_on = ctrl_q[PDS_CTRL_SUSP_PD] && suspend && power_enable_n;
    always_comb
    begin
        lower_port_out = {PDS_LO_W{1'b0}};
        lower_port_out[PDS_LO_TXD] = uart_txd;
        lower_port_out[PDS_LO_RTS] = uart_rts_n;
        lower_port_out[PDS_LO_DTR] = uart_dtr_n;
        lower_port_oe = PDS_LO_OE_MASK;
        lower_port_pu = pd_on ? {PDS_LO_W{1'b0}} : PDS_LO_IN_MASK;
        lower_port_pd = pd_on ? PDS_LO_IN_MASK : {PDS_LO_W{1'b0}};
    end
    // inputs registered, data outputs from flops
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            uart_rxd <= 1'b1;
            uart_cts_n <= 1'b1;
            uart_dsr_n <= 1'b1;
            uart_dcd_n <= 1'b1;
            ring_indicator_n <= 1'b1;
        end
        else
        begin
            uart_rxd <= lower_port_in[PDS_LO_RXD];
            uart_cts_n <= lower_port_in[PDS_LO_CTS];
            uart_dsr_n <= lower_port_in[PDS_LO_DSR];
            uart_dcd_n <= lower_port_in[PDS_LO_DCD];
            ring_indicator_n <= lower_port_in[PDS_LO_RI];
        end
    // ring low while suspended with wake enabled asks for resume
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            resume_req <= 1'b0;
        else
            resume_req <= ctrl_q[PDS_CTRL_WAKE_EN] && suspend && !ring_indicator_n;
    // ==========================================================
    // power enable: low once configured, high in suspend
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            power_enable_n <= 1'b1;
        else
            power_enable_n <= !(ctrl_q[PDS_CTRL_CONFIGURED] && !suspend);
    // ==========================================================
    // upper port pads
    logic use_mem;
    logic [2*PDS_UP_W-1:0] sel_all;
    assign use_mem = present && done;
    // pins 0..4 sit in sel0 and pins 5..9 in sel1; one flat vector avoids a negative index
    assign sel_all = {sel1_q[2*PDS_SEL_PINS-1:0], sel0_q[2*PDS_SEL_PINS-1:0]};
    always_comb
    begin
        logic [1:0] fn;
        fn = 2'h0;
        upper_pad = '0;
        for (int i = 0; i < PDS_UP_W; i++)
        begin
            fn = sel_all[2*i +: 2];
            if (!use_mem)
            begin
                // defaults without memory
                upper_pad.pu[i] = (i != PDS_UP_PD_BIT) && !pd_on;
                upper_pad.pd[i] = (i == PDS_UP_PD_BIT) || pd_on;
            end
            else
            begin
                case (fn)
                    PDS_FN_DRIVE0:
                    begin
                        upper_pad.oe[i] = 1'b1;
                    end
                    PDS_FN_DRIVE1:
                    begin
                        upper_pad.oe[i] = 1'b1;
                        upper_pad.out[i] = 1'b1;
                    end
                    PDS_FN_POWER_ENABLE_N:
                    begin
                        upper_pad.oe[i] = 1'b1;
                        upper_pad.out[i] = power_enable_n;
                    end
                    default:
                    begin
                        upper_pad.pu[i] = !pd_on;
                        upper_pad.pd[i] = pd_on;
                    end
                endcase
            end
        end
    end
    // ==========================================================
    // read mux, registered data
    logic [31:0] rd_d;
    always_comb
    begin
        case (haddr)
            PDS_CTRL_OFS: rd_d = ctrl_q;
            PDS_SEL0_OFS: rd_d = sel0_q;
            PDS_SEL1_OFS: rd_d = sel1_q;
            PDS_STAT_OFS: rd_d = {29'h0, resume_req, power_enable_n, use_mem};
            PDS_DRV_OFS: rd_d = {22'h0, upper_pad.oe};
            PDS_IN_OFS: rd_d = {14'h0, upper_port_in, lower_port_in};
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (acc && !hwrite)
            hrdata <= rd_d;
    // ==========================================================
    // checks
    a_power_enable_n_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[PDS_CTRL_CONFIGURED] && !suspend |=> !power_enable_n)
        else $error("power enable not low when configured");
    a_susp_power_enable_n: assert property (@(posedge hclk) disable iff (!hresetn)
        suspend |=> power_enable_n)
        else $error("power enable not high in suspend");
    a_ring_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[PDS_CTRL_WAKE_EN] && suspend && !ring_indicator_n |=> resume_req)
        else $error("no resume on ring");
    // ring pin low, one registered input stage, then the resume request
    sequence s_ring_pin_low;
        ctrl_q[PDS_CTRL_WAKE_EN] && suspend && !lower_port_in[PDS_LO_RI];
    endsequence
    sequence s_wake_held;
        ctrl_q[PDS_CTRL_WAKE_EN] && suspend;
    endsequence
    a_pin_resume: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ring_pin_low ##1 s_wake_held |=> resume_req)
        else $error("ring pin low gave no resume");
    a_up7_default: assert property (@(posedge hclk) disable iff (!hresetn)
        !use_mem && !pd_on |-> upper_pad.pd[PDS_UP_PD_BIT] && !upper_pad.pu[PDS_UP_PD_BIT])
        else $error("pin 7 default wrong");
    a_up0_default: assert property (@(posedge hclk) disable iff (!hresetn)
        !use_mem && !pd_on |-> upper_pad.pu[0] && upper_pad.oe == '0)
        else $error("upper default wrong");
    a_stored_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        !use_mem |-> upper_pad.oe == '0)
        else $error("upper pin driven before memory read done");
    a_ri_sample: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ring_indicator_n == $past(lower_port_in[PDS_LO_RI]))
        else $error("ring input not sampled");
    a_tx_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        lower_port_oe[PDS_LO_TXD] && lower_port_out[PDS_LO_TXD] == uart_txd)
        else $error("transmit not driven");
    a_mem_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(mem_oe_q) |-> cfg_mem_clock_oe && cfg_mem_select_oe)
        else $error("memory clock not driven after reset");
    // no disable here: this one must hold exactly while reset is low
    a_reset_float: assert property (@(posedge hclk)
        !hresetn |-> !cfg_mem_select_oe && !cfg_mem_clock_oe && !cfg_mem_data_oe)
        else $error("memory pins driven in reset");
    a_susp_pull: assert property (@(posedge hclk) disable iff (!hresetn)
        pd_on |-> lower_port_pd[PDS_LO_RXD] && !lower_port_pu[PDS_LO_RXD])
        else $error("suspend pull-down missing");
endmodule : pds_pins

// ### testbench/pds_far.sv
// far-side model: modem lines on the lower port, loads on the upper port
// assumes the device pad controls are combinational and one clock domain
`timescale 1ns/1ps
module pds_far
    import pds_pkg::*;
(
    input wire logic ring_low,
    input wire logic [3:0] modem_lvl,
    input wire logic [7:0] lo_out,
    input wire pds_pad_t up,
    output logic [7:0] lo_in,
    output logic [9:0] up_in
);
    // ==========================================================
    // wire levels
    // the modem owns bits 1,3,5,6,7; the device drives 0,2,4
    assign lo_in = {~ring_low, modem_lvl[3:2], lo_out[4], modem_lvl[1], lo_out[2], modem_lvl[0], lo_out[0]};
    // an undriven pin settles to its pull; pull-down wins over the idle high
    assign up_in = (up.oe & up.out) | (~up.oe & ~up.pd);
endmodule : pds_far

// ### testbench/pin_default_and_reset_states_test.sv
// self-checking bench for the pin default and reset state block
// assumes one 200 MHz clock and an AHB-Lite master owned by this bench
`timescale 1ns/1ps
module pin_default_and_reset_states_test;
    import pds_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, ring_low = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic mem_cs = 1'b1, mem_clk = 1'b0, mem_dat = 1'b1, txd = 1'b1, rts_n = 1'b0, dtr_n = 1'b1;
    logic cs_o, cs_oe, ck_o, ck_oe, dt_o, dt_oe, rxd, cts_n, dsr_n, dcd_n, ri_n, pen_n, resume;
    logic [3:0] modem_lvl = 4'h0;
    logic [7:0] lo_in, lo_out, lo_oe, lo_pu, lo_pd;
    logic [9:0] up_in;
    pds_pad_t upad;
    int err_total = 0;
    int n_tests = 0;
    assign hready = hreadyout;
    pds_pins i_pds_pins (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .mem_cs_in(mem_cs), .mem_clk_in(mem_clk), .mem_data_in(mem_dat),
        .cfg_mem_select_o(cs_o), .cfg_mem_select_oe(cs_oe), .cfg_mem_clock_o(ck_o), .cfg_mem_clock_oe(ck_oe),
        .cfg_mem_data_o(dt_o), .cfg_mem_data_oe(dt_oe), .cfg_mem_data_i(), .uart_txd(txd),
        .uart_rts_n(rts_n), .uart_dtr_n(dtr_n), .uart_rxd(rxd), .uart_cts_n(cts_n), .uart_dsr_n(dsr_n),
        .uart_dcd_n(dcd_n), .ring_indicator_n(ri_n), .lower_port_in(lo_in), .lower_port_out(lo_out),
        .lower_port_oe(lo_oe), .lower_port_pu(lo_pu), .lower_port_pd(lo_pd), .upper_port_in(up_in),
        .upper_pad(upad), .power_enable_n(pen_n), .resume_req(resume));
    pds_far i_pds_far (.ring_low(ring_low), .modem_lvl(modem_lvl), .lo_out(lo_out), .up(upad),
        .lo_in(lo_in), .up_in(up_in));
    // ==========================================================
    // clock and helpers
    initial
    begin
        forever #2.5 hclk = ~hclk;
    end
    task tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tick
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk
    // one single word transfer; the address phase holds until hready is seen high
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        tick(3); // register effect, then one more registered stage
    endtask : bus
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // scenarios
    task t_lower;
        tick(2);
        chk("lower oe", 8'h15, lo_oe);
        chk("lower out", {29'h0, dtr_n, rts_n, txd}, {29'h0, lo_out[4], lo_out[2], lo_out[0]});
        chk("lower pu", 8'hea, lo_pu);
        chk("lower pd", 8'h00, lo_pd);
        @(posedge hclk);
        modem_lvl <= 4'ha;
        tick(2);
        chk("modem ins", 5'h1a, {ri_n, dcd_n, dsr_n, cts_n, rxd});
        bus(1'b0, PDS_IN_OFS, 32'h0);
        chk("pin read", 32'h0003_7fd9, rd);
        $display("lower port test done");
    endtask : t_lower
    task t_stored;
        chk("upper pu", 10'h37f, upad.pu);
        chk("upper pd", 10'h080, upad.pd);
        chk("upper oe", 10'h000, upad.oe);
        bus(1'b1, PDS_SEL0_OFS, 32'h6);
        chk("early oe", 2'h0, upad.oe[1:0]);
        // memory present but its read not finished: defaults stay, reader owns the data pin
        bus(1'b1, PDS_CTRL_OFS, 32'h2);
        chk("reading oe", 10'h000, upad.oe);
        chk("data drive", {1'b1, mem_dat}, {dt_oe, dt_o});
        bus(1'b1, PDS_CTRL_OFS, 32'h3);
        chk("data released", 1'b0, dt_oe);
        chk("stored oe", 2'h3, upad.oe[1:0]);
        chk("stored out", 2'h1, upad.out[1:0]);
        bus(1'b0, PDS_CTRL_OFS, 32'h0);
        chk("ctrl read", 32'h3, rd);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("stored function test done");
    endtask : t_stored
    task t_power;
        // option set but not suspended: pull-ups stay
        bus(1'b1, PDS_CTRL_OFS, 32'h8);
        chk("idle pd", 8'h00, lo_pd);
        bus(1'b1, PDS_SEL0_OFS, 32'h3);
        bus(1'b1, PDS_CTRL_OFS, 32'h13);
        chk("pwr configured", 1'b0, pen_n);
        chk("power_enable_n pin", 2'h2, {upad.oe[0], upad.out[0]});
        bus(1'b0, PDS_DRV_OFS, 32'h0);
        chk("drive read", 32'h1, rd);
        bus(1'b1, PDS_CTRL_OFS, 32'h3b);
        chk("pwr suspend", 1'b1, pen_n);
        chk("power_enable_n pin susp", 2'h3, {upad.oe[0], upad.out[0]});
        chk("susp pd", 10'h3fe, upad.pd);
        chk("susp pu", 10'h000, upad.pu);
        chk("susp lower pd", 8'hea, lo_pd);
        $display("power test done");
    endtask : t_power
    task t_wake;
        bus(1'b1, PDS_CTRL_OFS, 32'h24);
        chk("no ring", 1'b0, resume);
        @(posedge hclk);
        ring_low <= 1'b1;
        tick(3);
        chk("ring resume", 1'b1, resume);
        bus(1'b0, PDS_STAT_OFS, 32'h0);
        chk("stat read", 32'h6, rd);
        bus(1'b1, PDS_CTRL_OFS, 32'h20);
        chk("wake off", 1'b0, resume);
        @(posedge hclk);
        ring_low <= 1'b0;
        $display("wake test done");
    endtask : t_wake
    // reset in mid-run: every memory pin must let go at once; select and clock come back after release, data stays off
    task t_reset;
        bus(1'b1, PDS_CTRL_OFS, 32'h12);
        chk("pre reset", 3'h7, {cs_oe, ck_oe, dt_oe});
        @(posedge hclk);
        hresetn <= 1'b0;
        tick(1);
        chk("mid reset oe", 3'h0, {cs_oe, ck_oe, dt_oe});
        chk("mid reset pwr", 1'b1, pen_n);
        chk("mid reset pd", 10'h080, upad.pd);
        @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        chk("reset release", 2'h3, {cs_oe, ck_oe});
        chk("data after reset", 1'b0, dt_oe);
        $display("mid-run reset test done");
    endtask : t_reset
    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        tick(2);
        chk("reset oe", 3'h0, {cs_oe, ck_oe, dt_oe});
        chk("reset pwr", 1'b1, pen_n);
        @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        chk("clock drive", {1'b1, mem_clk}, {ck_oe, ck_o});
        chk("select drive", {1'b1, mem_cs}, {cs_oe, cs_o});
        chk("data oe", 1'b0, dt_oe);
        t_lower();
        t_stored();
        t_power();
        t_wake();
        t_reset();
        print_verdict();
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        err_total++;
        print_verdict();
    end
endmodule : pin_default_and_reset_states_test
